/* File: logic/ars_defines.vh */
`ifndef ARS_DEFINES_VH
`define ARS_DEFINES_VH

// register byte offsets
`define ARS_CFG_ADDR        6'h00
`define ARS_VSF_ADDR        6'h04
`define ARS_VEF_ADDR        6'h08
`define ARS_VSP_ADDR        6'h0c
`define ARS_VEP_ADDR        6'h10
`define ARS_CSF_ADDR        6'h14
`define ARS_CEF_ADDR        6'h18
`define ARS_CSP_ADDR        6'h1c
`define ARS_CEP_ADDR        6'h20
`define ARS_STAT_ADDR       6'h24

// configuration word fields
`define ARS_CFG_SEL_LSB     0
`define ARS_CFG_VBELOW_BIT  2
`define ARS_CFG_CBELOW_BIT  3
`define ARS_CFG_AVG_LSB     4
`define ARS_CFG_SRC_LSB     8

// status word fields
`define ARS_STAT_USE_BIT    16
`define ARS_STAT_RUN_BIT    17

// reset values
`define ARS_SEL_RST         2'h0
`define ARS_BELOW_RST       1'h1
`define ARS_AVG_RST         4'h8
`define ARS_SRC_RST         2'h1
`define ARS_FREQ_RST        12'h000
`define ARS_SPCT_RST        7'h00
`define ARS_EPCT_RST        7'h64

// limits and codes
`define ARS_FREQ_MAX        12'hfa0
`define ARS_PCT_MAX         7'h64
`define ARS_AVG_MAX         4'h8
`define ARS_ADC_FULL        10'h3ff
`define ARS_SRC_TERMINAL    2'h1
`define ARS_SEL_SINGLE      2'h0
`define ARS_SEL_SUM         2'h1
`define ARS_SEL_VOLT_POT    2'h2
`define ARS_SEL_CURR_POT    2'h3

`endif

/* File: logic/ars_top.v */
`timescale 1ns/10ps
`include "ars_defines.vh"

module ars_top (
   // clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // wishbone classic slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [5:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // converter samples
   input  wire        adc_valid_i,
   input  wire [9:0]  volt_ref_input_i,
   input  wire [9:0]  current_ref_input_i,
   input  wire [9:0]  keypad_pot_input_i,
   // terminals and drive state
   input  wire        channel_switch_input_i,
   input  wire        terminal_program_switch_i,
   input  wire        motor_running_i,
   // frequency command
   output reg  [11:0] freq_cmd_o,
   output reg         freq_valid_o,
   output reg         use_analog_o
);

   // settings
   reg  [1:0]  channel_pair_select;
   reg         volt_below_span_choice;
   reg         curr_below_span_choice;
   reg  [3:0]  sample_average_count;
   reg  [1:0]  freq_source;
   reg  [11:0] volt_span_start_freq;
   reg  [11:0] volt_span_end_freq;
   reg  [6:0]  volt_span_start_pct;
   reg  [6:0]  volt_span_end_pct;
   reg  [11:0] curr_span_start_freq;
   reg  [11:0] curr_span_end_freq;
   reg  [6:0]  curr_span_start_pct;
   reg  [6:0]  curr_span_end_pct;

   // sample history
   reg  [9:0]  volt_hist [0:7];
   reg  [9:0]  curr_hist [0:7];
   reg  [9:0]  pot_hist  [0:7];
   reg  [2:0]  wr_ptr;
   reg         calc_pending;

   // bus decode
   wire        bus_req;
   wire        bus_wr;
   wire [15:0] wdat;
   wire [15:0] cfg_word;

   // datapath
   reg  [12:0] volt_sum;
   reg  [12:0] curr_sum;
   reg  [12:0] pot_sum;
   reg  [2:0]  rd_idx;
   integer     k;
   integer     j;
   wire [9:0]  volt_avg;
   wire [9:0]  curr_avg;
   wire [9:0]  pot_avg;
   wire [11:0] volt_freq;
   wire [11:0] curr_freq;
   wire [11:0] pot_freq;
   reg  [11:0] next_freq;

   // merge low two byte lanes into an old value
   function [15:0] merge16;
      input [15:0] old_v;
      input [15:0] new_v;
      input [1:0]  sel;
      begin
         merge16 = old_v;
         if (sel[0])
            merge16[7:0] = new_v[7:0];
         if (sel[1])
            merge16[15:8] = new_v[15:8];
      end
   endfunction

   // divide a history sum by the configured sample count
   function [9:0] avg_div;
      input [12:0] s;
      input [3:0]  n;
      reg   [12:0] q;
      begin
         case (n)
            4'h1: q = s;
            4'h2: q = s >> 1;
            4'h3: q = s / 13'h0003;
            4'h4: q = s >> 2;
            4'h5: q = s / 13'h0005;
            4'h6: q = s / 13'h0006;
            4'h7: q = s / 13'h0007;
            default: q = s >> 3;
         endcase
         avg_div = q[9:0];
      end
   endfunction

   // piecewise-linear map of one averaged sample onto a frequency
   function [11:0] map_freq;
      input [9:0]  x;
      input [11:0] fs;
      input [11:0] fe;
      input [6:0]  ps;
      input [6:0]  pe;
      input        below_zero;
      reg   [16:0] xs;
      reg   [16:0] lo;
      reg   [16:0] hi;
      reg   signed [31:0] num;
      reg   signed [31:0] den;
      reg   signed [31:0] res;
      begin
         // fraction of full scale kept exact by cross-multiplying
         xs  = {7'h00, x} * 17'h00064;
         lo  = {10'h000, ps} * {7'h00, `ARS_ADC_FULL};
         hi  = {10'h000, pe} * {7'h00, `ARS_ADC_FULL};
         num = 32'sh0;
         den = 32'sh1;
         res = 32'sh0;
         if (xs < lo) begin
            map_freq = below_zero ? 12'h000 : fs;
         end else if (xs >= hi) begin
            map_freq = fe;
         end else begin
            // signed slope so a falling curve works too
            num = ($signed({20'h00000, fe}) - $signed({20'h00000, fs}))
                  * $signed({15'h0000, xs - lo});
            den = $signed({15'h0000, hi - lo});
            res = $signed({20'h00000, fs}) + num / den;
            map_freq = res[11:0];
         end
      end
   endfunction

   // frequency setting accepted only inside the documented range
   function freq_ok;
      input [15:0] v;
      begin
         freq_ok = (v <= {4'h0, `ARS_FREQ_MAX});
      end
   endfunction

   // percentage setting accepted only from 0 to 100
   function pct_ok;
      input [15:0] v;
      begin
         pct_ok = (v <= {9'h000, `ARS_PCT_MAX});
      end
   endfunction

   assign bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // settings are frozen while the motor turns
   assign bus_wr   = bus_req & wb_we_i & ~motor_running_i;
   assign cfg_word = {6'h00, freq_source, sample_average_count,
                      curr_below_span_choice, volt_below_span_choice,
                      channel_pair_select};

   // settings written with byte lanes merged before range checks
   assign wdat = merge16(
      (wb_adr_i == `ARS_CFG_ADDR) ? cfg_word :
      (wb_adr_i == `ARS_VSF_ADDR) ? {4'h0, volt_span_start_freq} :
      (wb_adr_i == `ARS_VEF_ADDR) ? {4'h0, volt_span_end_freq} :
      (wb_adr_i == `ARS_VSP_ADDR) ? {9'h000, volt_span_start_pct} :
      (wb_adr_i == `ARS_VEP_ADDR) ? {9'h000, volt_span_end_pct} :
      (wb_adr_i == `ARS_CSF_ADDR) ? {4'h0, curr_span_start_freq} :
      (wb_adr_i == `ARS_CEF_ADDR) ? {4'h0, curr_span_end_freq} :
      (wb_adr_i == `ARS_CSP_ADDR) ? {9'h000, curr_span_start_pct} :
      {9'h000, curr_span_end_pct},
      wb_dat_i[15:0], wb_sel_i[1:0]);

   // wishbone answer one cycle after the request, unmapped reads zero
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_req) begin
            case (wb_adr_i)
               `ARS_CFG_ADDR: wb_dat_o <= {16'h0000, cfg_word};
               `ARS_VSF_ADDR: wb_dat_o <= {20'h00000, volt_span_start_freq};
               `ARS_VEF_ADDR: wb_dat_o <= {20'h00000, volt_span_end_freq};
               `ARS_VSP_ADDR: wb_dat_o <= {25'h0000000, volt_span_start_pct};
               `ARS_VEP_ADDR: wb_dat_o <= {25'h0000000, volt_span_end_pct};
               `ARS_CSF_ADDR: wb_dat_o <= {20'h00000, curr_span_start_freq};
               `ARS_CEF_ADDR: wb_dat_o <= {20'h00000, curr_span_end_freq};
               `ARS_CSP_ADDR: wb_dat_o <= {25'h0000000, curr_span_start_pct};
               `ARS_CEP_ADDR: wb_dat_o <= {25'h0000000, curr_span_end_pct};
               `ARS_STAT_ADDR: wb_dat_o <= {14'h0000, motor_running_i, use_analog_o,
                                            4'h0, freq_cmd_o};
               default: wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end

   // setting registers, out-of-range span values are dropped whole, a bad count in the config word drops only the count
   always @(posedge clk_i) begin
      if (rst_i) begin
         channel_pair_select    <= `ARS_SEL_RST;
         volt_below_span_choice <= `ARS_BELOW_RST;
         curr_below_span_choice <= `ARS_BELOW_RST;
         sample_average_count   <= `ARS_AVG_RST;
         freq_source            <= `ARS_SRC_RST;
         volt_span_start_freq   <= `ARS_FREQ_RST;
         volt_span_end_freq     <= `ARS_FREQ_RST;
         volt_span_start_pct    <= `ARS_SPCT_RST;
         volt_span_end_pct      <= `ARS_EPCT_RST;
         curr_span_start_freq   <= `ARS_FREQ_RST;
         curr_span_end_freq     <= `ARS_FREQ_RST;
         curr_span_start_pct    <= `ARS_SPCT_RST;
         curr_span_end_pct      <= `ARS_EPCT_RST;
      end else if (bus_wr) begin
         case (wb_adr_i)
            `ARS_CFG_ADDR: begin
               channel_pair_select    <= wdat[`ARS_CFG_SEL_LSB +: 2];
               volt_below_span_choice <= wdat[`ARS_CFG_VBELOW_BIT];
               curr_below_span_choice <= wdat[`ARS_CFG_CBELOW_BIT];
               freq_source            <= wdat[`ARS_CFG_SRC_LSB +: 2];
               // a count of 0 or above 8 keeps the old count
               if (wdat[`ARS_CFG_AVG_LSB +: 4] != 4'h0 &&
                   wdat[`ARS_CFG_AVG_LSB +: 4] <= `ARS_AVG_MAX) begin
                  sample_average_count <= wdat[`ARS_CFG_AVG_LSB +: 4];
               end
            end
            `ARS_VSF_ADDR: if (freq_ok(wdat)) volt_span_start_freq <= wdat[11:0];
            `ARS_VEF_ADDR: if (freq_ok(wdat)) volt_span_end_freq <= wdat[11:0];
            `ARS_VSP_ADDR: if (pct_ok(wdat)) volt_span_start_pct <= wdat[6:0];
            `ARS_VEP_ADDR: if (pct_ok(wdat)) volt_span_end_pct <= wdat[6:0];
            `ARS_CSF_ADDR: if (freq_ok(wdat)) curr_span_start_freq <= wdat[11:0];
            `ARS_CEF_ADDR: if (freq_ok(wdat)) curr_span_end_freq <= wdat[11:0];
            `ARS_CSP_ADDR: if (pct_ok(wdat)) curr_span_start_pct <= wdat[6:0];
            `ARS_CEP_ADDR: if (pct_ok(wdat)) curr_span_end_pct <= wdat[6:0];
            default: ;
         endcase
      end
   end

   // sample history ring, one slot per converter strobe
   always @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr       <= 3'h0;
         calc_pending <= 1'b0;
         for (k = 0; k < 8; k = k + 1) begin
            volt_hist[k] <= 10'h000;
            curr_hist[k] <= 10'h000;
            pot_hist[k]  <= 10'h000;
         end
      end else begin
         calc_pending <= adc_valid_i;
         if (adc_valid_i) begin
            volt_hist[wr_ptr] <= volt_ref_input_i;
            curr_hist[wr_ptr] <= current_ref_input_i;
            pot_hist[wr_ptr]  <= keypad_pot_input_i;
            wr_ptr            <= wr_ptr + 3'h1;
         end
      end
   end

   // sum of the latest n entries, walking back from the write pointer
   // own loop index so the reset loop above stays the only writer of k
   // slots beyond the strobes seen since reset read as zero
   always @* begin
      volt_sum = 13'h0000;
      curr_sum = 13'h0000;
      pot_sum  = 13'h0000;
      rd_idx   = 3'h0;
      for (j = 1; j <= 8; j = j + 1) begin
         rd_idx = wr_ptr - j[2:0];
         if (j[3:0] <= sample_average_count) begin
            volt_sum = volt_sum + {3'h0, volt_hist[rd_idx]};
            curr_sum = curr_sum + {3'h0, curr_hist[rd_idx]};
            pot_sum  = pot_sum + {3'h0, pot_hist[rd_idx]};
         end
      end
   end

   assign volt_avg = avg_div(volt_sum, sample_average_count);
   assign curr_avg = avg_div(curr_sum, sample_average_count);
   assign pot_avg  = avg_div(pot_sum, sample_average_count);

   // the keypad pot shares the voltage curve
   assign volt_freq = map_freq(volt_avg, volt_span_start_freq, volt_span_end_freq,
                               volt_span_start_pct, volt_span_end_pct,
                               volt_below_span_choice);
   assign pot_freq  = map_freq(pot_avg, volt_span_start_freq, volt_span_end_freq,
                               volt_span_start_pct, volt_span_end_pct,
                               volt_below_span_choice);
   assign curr_freq = map_freq(curr_avg, curr_span_start_freq, curr_span_end_freq,
                               curr_span_start_pct, curr_span_end_pct,
                               curr_below_span_choice);

   // channel selection; outside the sum code the switch high picks the second source
   always @* begin
      case (channel_pair_select)
         `ARS_SEL_SINGLE:
            next_freq = channel_switch_input_i ? curr_freq : volt_freq;
         `ARS_SEL_SUM: begin
            // sum saturates at the top of the frequency range
            if ({1'b0, volt_freq} + {1'b0, curr_freq} > {1'b0, `ARS_FREQ_MAX})
               next_freq = `ARS_FREQ_MAX;
            else
               next_freq = volt_freq + curr_freq;
         end
         `ARS_SEL_VOLT_POT:
            next_freq = channel_switch_input_i ? pot_freq : volt_freq;
         `ARS_SEL_CURR_POT:
            next_freq = channel_switch_input_i ? pot_freq : curr_freq;
         default:
            next_freq = volt_freq;
      endcase
   end

   // command output, refreshed two cycles after each sample strobe
   // a strobe every cycle is fine: the pending flag and result are one deep
   always @(posedge clk_i) begin
      if (rst_i) begin
         freq_cmd_o   <= 12'h000;
         freq_valid_o <= 1'b0;
         use_analog_o <= 1'b0;
      end else begin
         freq_valid_o <= calc_pending;
         // terminal position forces analog source over the setting
         use_analog_o <= terminal_program_switch_i |
                         (freq_source == `ARS_SRC_TERMINAL);
         if (calc_pending)
            freq_cmd_o <= next_freq;
      end
   end

endmodule // ars_top

/* File: verif/ars_props.sv */
`timescale 1ns/10ps
module ars_props (
   // clock and reset
   input wire        clk_i,
   input wire        rst_i,
   // register bus
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_we_i,
   input wire [5:0]  wb_adr_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   // sample stream and command
   input wire        adc_valid_i,
   input wire        terminal_program_switch_i,
   input wire [11:0] freq_cmd_o,
   input wire        freq_valid_o,
   input wire        use_analog_o
);
   default clocking dcb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // bus answers: one cycle late, one cycle wide
   a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack stood longer than one cycle");
   a_ack_after_req: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("request not answered in one cycle");
   a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
      else $error("ack without a request");
   a_rd_unmapped_zero: assert property ((wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
      && wb_adr_i == 6'h28) |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   // result pulse two cycles after each strobe, command held between
   a_valid_two_late: assert property (adc_valid_i |-> ##2 freq_valid_o)
      else $error("no result two cycles after sample");
   a_valid_has_cause: assert property (freq_valid_o |-> $past(adc_valid_i, 2))
      else $error("result without sample");
   a_cmd_holds: assert property (!freq_valid_o |-> $stable(freq_cmd_o))
      else $error("command moved without valid");
   a_cmd_in_range: assert property (freq_valid_o |-> freq_cmd_o <= 12'hfa0)
      else $error("command above 400 Hz");
   a_term_forces: assert property ($past(terminal_program_switch_i) && !$past(rst_i)
      |-> use_analog_o)
      else $error("terminal position did not select analog");
endmodule // ars_props

bind ars_top ars_props u_ars_props (
   .clk_i                     (clk_i),
   .rst_i                     (rst_i),
   .wb_cyc_i                  (wb_cyc_i),
   .wb_stb_i                  (wb_stb_i),
   .wb_we_i                   (wb_we_i),
   .wb_adr_i                  (wb_adr_i),
   .wb_dat_o                  (wb_dat_o),
   .wb_ack_o                  (wb_ack_o),
   .adc_valid_i               (adc_valid_i),
   .terminal_program_switch_i (terminal_program_switch_i),
   .freq_cmd_o                (freq_cmd_o),
   .freq_valid_o              (freq_valid_o),
   .use_analog_o              (use_analog_o)
);

/* File: verif/ars_adc_model.sv */
`timescale 1ns/10ps
module ars_adc_model (
   // clock
   input  wire        clk_i,
   // converted samples
   output logic       valid_o,
   output logic [9:0] volt_o,
   output logic [9:0] curr_o,
   output logic [9:0] pot_o
);
   // quiet converter at start
   initial begin
      valid_o = 1'b0;
      volt_o = 10'h0;
      curr_o = 10'h0;
      pot_o = 10'h0;
   end
   // one strobe; samples scrambled afterwards so stale data never looks valid
   task automatic send(input logic [9:0] v, input logic [9:0] c, input logic [9:0] p);
      @(posedge clk_i);
      valid_o <= 1'b1;
      volt_o <= v;
      curr_o <= c;
      pot_o <= p;
      @(posedge clk_i);
      valid_o <= 1'b0;
      volt_o <= ~v;
      curr_o <= ~c;
      pot_o <= ~p;
   endtask
endmodule // ars_adc_model

/* File: verif/tb_analog_reference_scaler.sv */
`timescale 1ns/10ps
module tb_analog_reference_scaler;
   logic        clk_i, rst_i, cyc, stb, we, sw, tps, run;
   logic [5:0]  adr;
   logic [31:0] wdat;
   wire  [31:0] rdat;
   wire         ack, adc_v, fval, fuse;
   wire  [9:0]  av, ac, ap;
   wire  [11:0] fcmd;
   int          err_total, check_count, cyc_cnt, last_f, v, c, p;
   int          fq[$];
   logic [31:0] rq[$];

   ars_top u_ars_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .adc_valid_i(adc_v), .volt_ref_input_i(av), .current_ref_input_i(ac),
      .keypad_pot_input_i(ap), .channel_switch_input_i(sw), .terminal_program_switch_i(tps),
      .motor_running_i(run), .freq_cmd_o(fcmd), .freq_valid_o(fval), .use_analog_o(fuse));
   ars_adc_model u_ars_adc_model (.clk_i(clk_i), .valid_o(adc_v), .volt_o(av),
      .curr_o(ac), .pot_o(ap));

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   function automatic logic [31:0] cfg(input int s, input int vb, input int n, input int src);
      return {22'h0, 2'(src), 4'(n), ~1'(vb), 1'(vb), 2'(s)};
   endfunction
   // linear segment with clamping; integer division truncates toward zero
   function automatic int fmap(int x, int fs, int fe, int ps, int pe, int bz);
      int xs, lo, hi;
      xs = x * 100;
      lo = ps * 1023;
      hi = pe * 1023;
      if (xs < lo) return bz ? 0 : fs;
      if (xs >= hi) return fe;
      return fs + (fe - fs) * (xs - lo) / (hi - lo);
   endfunction
   // pot follows the voltage curve; current below-choice is the inverse of voltage's
   function automatic int fexp(int s, int w, int b, int vv, int cc, int pp);
      int vm, cm, pm;
      vm = fmap(vv, 100, 3000, 10, 90, b);
      cm = fmap(cc, 500, 4000, 20, 80, !b);
      pm = fmap(pp, 100, 3000, 10, 90, b);
      case (s)
         0: return w ? cm : vm;
         1: return (vm + cm > 4000) ? 4000 : vm + cm;
         2: return w ? pm : vm;
         default: return w ? pm : cm;
      endcase
   endfunction
   function automatic int pick(int k);
      return (k == 0) ? 0 : (k == 1) ? 1023 : $urandom_range(1023);
   endfunction

   // classic single cycle; read expectations queued for the monitor
   task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d,
                     input logic [31:0] e);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      if (!w) rq.push_back(e);
      do @(posedge clk_i); while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic samp(input int e, input int vv, input int cc, input int pp);
      fq.push_back(e);
      last_f = e;
      u_ars_adc_model.send(10'(vv), 10'(cc), 10'(pp));
      // let the result edge pass before the caller moves the switch
      @(posedge clk_i);
   endtask
   task chk_freq(input logic [31:0] e, input logic [11:0] g);
      check_count++;
      if ({20'h0, g} !== e) begin
         err_total++;
         $display("ERROR freq_cmd_o expected %h seen %h", e, g);
      end
   endtask
   task chk_read(input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("ERROR wb_dat_o expected %h seen %h", e, g);
      end
   endtask
   task report_and_stop;
      // a result that never came counts against the run
      if (fq.size() != 0 || rq.size() != 0)
         err_total++;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // monitor: oldest note against each result seen
   always @(posedge clk_i) begin
      if (fval === 1'b1)
         chk_freq(fq.size() ? fq.pop_front() : 32'hffffffff, fcmd);
      if (ack === 1'b1 && !we)
         chk_read(rq.size() ? rq.pop_front() : 32'hdeadbeef, rdat);
   end
   // hang guard, far above the few hundred cycles the run needs
   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000) begin
         err_total++;
         report_and_stop;
      end
   end

   initial begin
      rst_i = 1'b1;
      {cyc, stb, we, sw, tps, run} = 6'h0;
      adr = 6'h0;
      wdat = 32'h0;
      {err_total, check_count, cyc_cnt, last_f} = '0;
      void'($urandom(32'h2866));
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, 6'h00, 32'h0, 32'h18c);
      wb(1'b0, 6'h0c, 32'h0, 32'h0);
      wb(1'b0, 6'h10, 32'h0, 32'h64);
      wb(1'b0, 6'h20, 32'h0, 32'h64);
      wb(1'b0, 6'h28, 32'h0, 32'h0);
      wb(1'b0, 6'h24, 32'h0, 32'h10000);
      $display("test reset_values done");
      wb(1'b1, 6'h04, 32'h64, 32'h0);
      wb(1'b1, 6'h08, 32'hbb8, 32'h0);
      wb(1'b1, 6'h0c, 32'ha, 32'h0);
      wb(1'b1, 6'h10, 32'h5a, 32'h0);
      wb(1'b1, 6'h14, 32'h1f4, 32'h0);
      wb(1'b1, 6'h18, 32'hfa0, 32'h0);
      wb(1'b1, 6'h1c, 32'h14, 32'h0);
      wb(1'b1, 6'h20, 32'h50, 32'h0);
      // every selection code, switch level and below-span choice
      for (int s = 0; s < 4; s++) for (int w = 0; w < 2; w++) for (int b = 0; b < 2; b++) begin
         sw <= w[0];
         wb(1'b1, 6'h00, cfg(s, b, 1, 1), 32'h0);
         for (int k = 0; k < 4; k++) begin
            v = pick(k);
            c = pick(k);
            p = pick(k);
            samp(fexp(s, w, b, v, c, p), v, c, p);
         end
      end
      $display("test channel_mapping done");
      sw <= 1'b0;
      wb(1'b1, 6'h00, cfg(0, 1, 1, 1), 32'h0);
      samp(fmap(600, 100, 3000, 10, 90, 1), 600, 600, 600);
      wb(1'b1, 6'h00, cfg(0, 1, 2, 1), 32'h0);
      samp(fmap(400, 100, 3000, 10, 90, 1), 200, 200, 200);
      samp(fmap(200, 100, 3000, 10, 90, 1), 200, 200, 200);
      // odd count uses a true divide: latest three are 500, 200, 200
      wb(1'b1, 6'h00, cfg(0, 1, 3, 1), 32'h0);
      samp(fmap(300, 100, 3000, 10, 90, 1), 500, 500, 500);
      // a count of 9 is refused and the count of 3 stays
      wb(1'b1, 6'h00, cfg(0, 1, 9, 1), 32'h0);
      wb(1'b0, 6'h00, 32'h0, cfg(0, 1, 3, 1));
      $display("test averaging done");
      run <= 1'b1;
      wb(1'b0, 6'h24, 32'h0, 32'h30000 | last_f);
      wb(1'b1, 6'h04, 32'h7, 32'h0);
      run <= 1'b0;
      wb(1'b0, 6'h04, 32'h0, 32'h64);
      wb(1'b1, 6'h08, 32'hfa1, 32'h0);
      wb(1'b0, 6'h08, 32'h0, 32'hbb8);
      $display("test write_refusal done");
      wb(1'b1, 6'h00, cfg(0, 1, 2, 0), 32'h0);
      wb(1'b0, 6'h24, 32'h0, last_f);
      tps <= 1'b1;
      @(posedge clk_i);
      wb(1'b0, 6'h24, 32'h0, 32'h10000 | last_f);
      $display("test terminal_switch done");
      repeat (4) @(posedge clk_i);
      report_and_stop;
   end
endmodule // tb_analog_reference_scaler
